/* File: core/cec_pkg.sv */
package cec_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;
    localparam logic [7:0]  OFS_PSTAT      = 8'h44;
    localparam logic [7:0]  OFS_IFLAGS     = 8'h50;
    localparam logic [7:0]  OFS_IENABLE    = 8'h54;
    localparam logic [7:0]  OFS_ISELECT    = 8'h58;
    localparam logic [31:0] RST_IFLAGS     = 32'h0000_0000;
    localparam logic [31:0] RST_IENABLE    = 32'h0000_0000;
    localparam logic [31:0] RST_ISELECT    = 32'h0000_0000;

    // ------------------------------------------------------------
    // Protocol status fields
    // ------------------------------------------------------------
    localparam int          POS_LEC        = 29;
    localparam int          POS_ACT        = 27;
    localparam int          POS_PASSIVE    = 26;
    localparam int          POS_WARN       = 25;
    localparam int          POS_BUS_OFF    = 24;
    localparam logic [2:0]  RST_LEC        = 3'h7;

    // ------------------------------------------------------------
    // Last error codes
    // ------------------------------------------------------------
    localparam logic [2:0]  CODE_NONE           = 3'h0;
    localparam logic [2:0]  CODE_STUFF          = 3'h1;
    localparam logic [2:0]  CODE_FORM           = 3'h2;
    localparam logic [2:0]  CODE_NO_ACK         = 3'h3;
    localparam logic [2:0]  CODE_RECESSIVE_LOST = 3'h4;
    localparam logic [2:0]  CODE_DOMINANT_LOST  = 3'h5;
    localparam logic [2:0]  CODE_CHECKSUM_BAD   = 3'h6;
    localparam logic [2:0]  CODE_NO_EVENT       = 3'h7;

    // ------------------------------------------------------------
    // Interrupt flag positions
    // ------------------------------------------------------------
    localparam int          FLG_STUFF      = 0;
    localparam int          FLG_FORMAT     = 1;
    localparam int          FLG_ACK        = 2;
    localparam int          FLG_BIT        = 3;
    localparam int          FLG_CHECKSUM   = 4;
    localparam int          FLG_BUS_OFF    = 6;
    localparam int          FLG_WARN       = 7;
    localparam int          FLG_PASSIVE    = 8;
    localparam logic [31:0] EXT_FLAG_MASK  = 32'hffff_fe20;

    // ------------------------------------------------------------
    // Carriers and decode
    // ------------------------------------------------------------
    typedef struct packed {
        logic recov11;
        logic frame_ok;
        logic checksum;
        logic dominant_lost;
        logic recessive_lost;
        logic no_ack;
        logic form;
        logic stuff;
    } cec_err_t;

    typedef struct packed {
        logic [1:0] activity;
        logic       passive;
        logic       warn;
        logic       bus_off;
    } cec_stat_t;

    typedef enum {
        SEL_NONE,
        SEL_PSTAT,
        SEL_IFLAGS,
        SEL_IENABLE,
        SEL_ISELECT
    } cec_sel_t;

endpackage

/* File: core/cec_flag_bank.sv */
`timescale 1ns/100ps
module cec_flag_bank #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    // Set and clear strobes
    input  wire logic [W-1:0] set_in,
    input  wire logic [W-1:0] clr_in,
    // Flags
    output logic      [W-1:0] flags_out
);

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flags_out <= '0;
        end else begin
            // A set in the clear cycle survives, so no event is lost.
            flags_out <= (flags_out & ~clr_in) | set_in;
        end
    end

endmodule // cec_flag_bank

/* File: core/cec_irq_route.sv */
`timescale 1ns/100ps
module cec_irq_route #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    // Flags and routing
    input  wire logic [W-1:0] flags_in,
    input  wire logic [W-1:0] enable_in,
    input  wire logic [W-1:0] select_in,
    // Lines
    output logic              line0_out,
    output logic              line1_out
);

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            line0_out <= 1'b0;
            line1_out <= 1'b0;
        end else begin
            line0_out <= |(flags_in & enable_in & ~select_in);
            line1_out <= |(flags_in & enable_in & select_in);
        end
    end

endmodule // cec_irq_route

/* File: core/cec_top.sv */
`timescale 1ns/100ps
module cec_top (
    // Clock and reset
    input  wire logic                     CLK_IN,
    input  wire logic                     RSTN_IN,

    // APB slave
    input  wire logic                     PSEL_IN,
    input  wire logic                     PENABLE_IN,
    input  wire logic                     PWRITE_IN,
    input  wire logic [cec_pkg::ADDR_W-1:0] PADDR_IN,
    input  wire logic [cec_pkg::DATA_W-1:0] PWDATA_IN,
    output logic      [cec_pkg::DATA_W-1:0] PRDATA_OUT,
    output logic                          PREADY_OUT,
    output logic                          PSLVERR_OUT,

    // Protocol engine events and state
    input  wire cec_pkg::cec_err_t        ERR_IN,
    input  wire cec_pkg::cec_stat_t       STAT_IN,
    input  wire logic [31:0]              EVT_IN,

    // Interrupt lines
    output logic                          INT0_OUT,
    output logic                          INT1_OUT,

    // Observation
    output logic [2:0]                    LEC_OUT
);
    import cec_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    cec_sel_t         sel;
    logic             hit;
    logic             setup_rd;
    logic             setup_any;
    logic             access;
    logic             access_wr;

    logic [2:0]       last_error_code_r;
    logic [2:0]       last_error_code_nxt;

    cec_stat_t        stat_r;
    cec_stat_t        stat_prev_r;
    logic             stat_primed_r;

    logic [31:0]      interrupt_flags;
    logic [31:0]      flag_set;
    logic [31:0]      flag_clr;
    logic [31:0]      flag_enable_r;
    logic [31:0]      line_select_r;

    logic [31:0]      pstat_word;
    logic [31:0]      rdata_nxt;
    logic [31:0]      prdata_r;
    logic             err_r;

    // ------------------------------------------------------------
    // Bus phase decode
    // ------------------------------------------------------------
    // The slave never stretches the access phase: read data is
    // captured at the setup edge, so one access cycle suffices.
    assign setup_any = PSEL_IN & ~PENABLE_IN;
    assign setup_rd  = setup_any & ~PWRITE_IN;
    assign access    = PSEL_IN & PENABLE_IN;
    assign access_wr = access & PWRITE_IN & hit;

    always_comb begin
        sel = SEL_NONE;
        case (PADDR_IN)
            OFS_PSTAT: begin
                sel = SEL_PSTAT;
            end
            OFS_IFLAGS: begin
                sel = SEL_IFLAGS;
            end
            OFS_IENABLE: begin
                sel = SEL_IENABLE;
            end
            OFS_ISELECT: begin
                sel = SEL_ISELECT;
            end
            default: begin
                sel = SEL_NONE;
            end
        endcase
    end

    assign hit = (sel != SEL_NONE);

    // ------------------------------------------------------------
    // Engine state sampling
    // ------------------------------------------------------------
    // The protocol engine shares this clock, so no synchroniser is
    // needed; one stage gives the previous value for change flags.
    // The first sample after reset primes both stages, so a status
    // that is already set when reset ends raises no change flag.
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            stat_r        <= '0;
            stat_prev_r   <= '0;
            stat_primed_r <= 1'b0;
        end else begin
            stat_r        <= STAT_IN;
            stat_prev_r   <= stat_primed_r ? stat_r : STAT_IN;
            stat_primed_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Last error code
    // ------------------------------------------------------------
    // Later assignments win: an error seen in the same cycle as a
    // status read is reported, never hidden by the read.
    always_comb begin
        last_error_code_nxt = last_error_code_r;
        if (setup_rd && sel == SEL_PSTAT) begin
            last_error_code_nxt = CODE_NO_EVENT;
        end
        if (ERR_IN.frame_ok) begin
            last_error_code_nxt = CODE_NONE;
        end
        if (ERR_IN.recov11) begin
            last_error_code_nxt = CODE_DOMINANT_LOST;
        end
        if (ERR_IN.checksum) begin
            last_error_code_nxt = CODE_CHECKSUM_BAD;
        end
        if (ERR_IN.dominant_lost) begin
            last_error_code_nxt = CODE_DOMINANT_LOST;
        end
        if (ERR_IN.recessive_lost) begin
            last_error_code_nxt = CODE_RECESSIVE_LOST;
        end
        if (ERR_IN.no_ack) begin
            last_error_code_nxt = CODE_NO_ACK;
        end
        if (ERR_IN.form) begin
            last_error_code_nxt = CODE_FORM;
        end
        if (ERR_IN.stuff) begin
            last_error_code_nxt = CODE_STUFF;
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            last_error_code_r <= RST_LEC;
        end else begin
            last_error_code_r <= last_error_code_nxt;
        end
    end

    assign LEC_OUT = last_error_code_r;

    // ------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------
    // Error flags take the same engine strobes as the code above,
    // so both change on one edge.
    always_comb begin
        flag_set = EVT_IN & EXT_FLAG_MASK;
        flag_set[FLG_STUFF]    = ERR_IN.stuff;
        flag_set[FLG_FORMAT]   = ERR_IN.form;
        flag_set[FLG_ACK]      = ERR_IN.no_ack;
        flag_set[FLG_BIT]      = ERR_IN.recessive_lost
                               | ERR_IN.dominant_lost;
        flag_set[FLG_CHECKSUM] = ERR_IN.checksum;
        flag_set[FLG_BUS_OFF]  = stat_r.bus_off ^ stat_prev_r.bus_off;
        flag_set[FLG_WARN]     = stat_r.warn ^ stat_prev_r.warn;
        flag_set[FLG_PASSIVE]  = stat_r.passive ^ stat_prev_r.passive;
    end

    // Zeros in the written word leave their flags alone.
    assign flag_clr = (access_wr && sel == SEL_IFLAGS) ? PWDATA_IN
                                                       : 32'h0000_0000;

    cec_flag_bank #(
        .W         (32)
    ) u_flags (
        .clk_in    (CLK_IN),
        .rstn_in   (RSTN_IN),
        .set_in    (flag_set),
        .clr_in    (flag_clr),
        .flags_out (interrupt_flags)
    );

    // ------------------------------------------------------------
    // Enable and line select
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            flag_enable_r <= RST_IENABLE;
        end else if (access_wr && sel == SEL_IENABLE) begin
            flag_enable_r <= PWDATA_IN;
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            line_select_r <= RST_ISELECT;
        end else if (access_wr && sel == SEL_ISELECT) begin
            line_select_r <= PWDATA_IN;
        end
    end

    // Lines are registered: a flag shows on its line one edge after
    // it sets, which keeps glitches off the interrupt pins.
    cec_irq_route #(
        .W         (32)
    ) u_route (
        .clk_in    (CLK_IN),
        .rstn_in   (RSTN_IN),
        .flags_in  (interrupt_flags),
        .enable_in (flag_enable_r),
        .select_in (line_select_r),
        .line0_out (INT0_OUT),
        .line1_out (INT1_OUT)
    );

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        pstat_word = 32'h0000_0000;
        pstat_word[POS_LEC +: 3]   = last_error_code_r;
        pstat_word[POS_ACT +: 2]   = stat_r.activity;
        pstat_word[POS_PASSIVE]    = stat_r.passive;
        pstat_word[POS_WARN]       = stat_r.warn;
        pstat_word[POS_BUS_OFF]    = stat_r.bus_off;
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (sel)
            SEL_PSTAT: begin
                rdata_nxt = pstat_word;
            end
            SEL_IFLAGS: begin
                rdata_nxt = interrupt_flags;
            end
            SEL_IENABLE: begin
                rdata_nxt = flag_enable_r;
            end
            SEL_ISELECT: begin
                rdata_nxt = line_select_r;
            end
            default: begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    // The word is frozen at the setup edge; the status read that
    // sets the code to 7 happens on that same edge, so software sees
    // the code from before its own read.
    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            err_r <= 1'b0;
        end else if (setup_any) begin
            err_r <= ~hit;
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    assign PRDATA_OUT  = prdata_r;
    assign PREADY_OUT  = access;
    assign PSLVERR_OUT = access & err_r;

endmodule // cec_top

/* File: verif/cec_props.sv */
`timescale 1ns/100ps
// ----------
// Checker
// ----------
module cec_props
    import cec_pkg::*;
(
    // Clock and reset
    input wire logic              CLK_IN,
    input wire logic              RSTN_IN,
    // Bus
    input wire logic              PSEL_IN,
    input wire logic              PENABLE_IN,
    input wire logic              PWRITE_IN,
    input wire logic [ADDR_W-1:0] PADDR_IN,
    input wire logic              PSLVERR_OUT,
    // Events and outputs
    input wire cec_err_t          ERR_IN,
    input wire logic              INT1_OUT,
    input wire logic [2:0]        LEC_OUT
);
    logic [7:0] e;
    logic       rd_ps;
    assign e = ERR_IN;
    assign rd_ps = PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN == OFS_PSTAT;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RSTN_IN);

    stuff_code_a: assert property (e[0] |=> LEC_OUT == 3'h1)
        else $error("stuff code not loaded");
    form_code_a: assert property (e[1:0] == 2'h2 |=> LEC_OUT == 3'h2)
        else $error("form code not loaded");
    ack_code_a: assert property (e[2:0] == 3'h4 |=> LEC_OUT == 3'h3)
        else $error("ack code not loaded");
    rec_code_a: assert property (e[3:0] == 4'h8 |=> LEC_OUT == 3'h4)
        else $error("recessive code not loaded");
    dom_code_a: assert property (e[4:0] == 5'h10 |=> LEC_OUT == 3'h5)
        else $error("dominant code not loaded");
    crc_code_a: assert property (e[5:0] == 6'h20 |=> LEC_OUT == 3'h6)
        else $error("checksum code not loaded");
    recov_code_a: assert property (e[7] && e[5:0] == 6'h0 |=> LEC_OUT == 3'h5)
        else $error("recovery code not loaded");
    ok_code_a: assert property (e == 8'h40 |=> LEC_OUT == 3'h0)
        else $error("clean frame did not clear code");
    read_code_a: assert property (rd_ps && e == 8'h0 |=> LEC_OUT == 3'h7)
        else $error("status read did not set code 7");
    lec_hold_a: assert property (e == 8'h0 && !rd_ps |=> $stable(LEC_OUT))
        else $error("code changed without cause");
    flag_map_a: assert property (PSEL_IN && PENABLE_IN && PADDR_IN == OFS_IFLAGS
        |-> !PSLVERR_OUT)
        else $error("flag register refused");

    cover property (e[0]);
    cover property (rd_ps);
    cover property ($rose(INT1_OUT));
    cover property (PSLVERR_OUT);
endmodule // cec_props

bind cec_top cec_props cec_props_i (.CLK_IN, .RSTN_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN,
    .PADDR_IN, .PSLVERR_OUT, .ERR_IN, .INT1_OUT, .LEC_OUT);

/* File: verif/cec_bus_model.sv */
`timescale 1ns/100ps
// ----------
// Protocol engine facing the bus
// ----------
module cec_bus_model
    import cec_pkg::*;
(
    // Clock
    input  wire logic  clk_in,
    // Reports
    output cec_err_t   err_out,
    output cec_stat_t  stat_out,
    output logic [31:0] evt_out
);
    initial begin
        err_out = '0;
        stat_out = '0;
        evt_out = '0;
    end

    // Each bus event is reported as a strobe lasting exactly one cycle.
    task automatic send(input logic [7:0] e, input logic [31:0] v);
        @(posedge clk_in);
        err_out <= e;
        evt_out <= v;
        @(posedge clk_in);
        err_out <= '0;
        evt_out <= '0;
    endtask

    task automatic set_stat(input cec_stat_t s);
        @(posedge clk_in);
        stat_out <= s;
    endtask
endmodule // cec_bus_model

/* File: verif/testbench.sv */
`timescale 1ns/100ps
module testbench;
    import cec_pkg::*;
    logic        clk, rstn, psel, pen, pwr, pready, pslverr, int0, int1, serr;
    logic [7:0]  paddr, e;
    logic [31:0] pwdata, prdata, rdata, expf, v;
    logic [2:0]  last_error_code, c;
    logic [15:0] seed;
    cec_err_t    err;
    cec_stat_t   stat;
    logic [31:0] evt;
    int          err_total, n_compared;

    cec_top cec_top_i (.CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ERR_IN(err), .STAT_IN(stat),
        .EVT_IN(evt), .INT0_OUT(int0), .INT1_OUT(int1), .LEC_OUT(last_error_code));
    cec_bus_model cec_bus_model_i (.clk_in(clk), .err_out(err), .stat_out(stat),
        .evt_out(evt));

    // ----------
    // Helpers
    // ----------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Lower bits win, and a recovery run outranks a clean frame.
    function automatic logic [2:0] exp_code(input logic [7:0] x);
        for (int i = 0; i < 6; i++) if (x[i]) return 3'(i + 1);
        return x[7] ? 3'h5 : 3'h0;
    endfunction

    function automatic logic [31:0] exp_flags(input logic [7:0] x);
        return {27'h0, x[5], x[4] | x[3], x[2:0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_compared++;
        if (got !== want) begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, got, want);
        end
    endtask

    task automatic chk_lec(input logic [2:0] want);
        chk({29'h0, last_error_code}, {29'h0, want});
    endtask

    task automatic chk_irq(input logic [1:0] want);
        chk({30'h0, int1, int0}, {30'h0, want});
    endtask

    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) begin
                rdata = prdata;
                serr = pslverr;
                psel <= 1'b0;
                pen <= 1'b0;
                return;
            end
        end
        err_total++;
        finish_test();
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test();
    end

    // ----------
    // Sequence
    // ----------
    initial begin
        {rstn, psel, pen, pwr, paddr, pwdata} = '0;
        err_total = 0;
        n_compared = 0;
        seed = 16'h005d;
        expf = 32'h0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b0, OFS_IFLAGS, 32'h0);
        chk(rdata, 32'h0);
        apb(1'b0, OFS_IENABLE, 32'h0);
        chk(rdata, RST_IENABLE);
        for (int k = 0; k < 8; k++) begin
            e = 8'h1 << k;
            c = exp_code(e);
            cec_bus_model_i.send(e, 32'h0);
            #1 chk_lec(c);
            apb(1'b0, OFS_PSTAT, 32'h0);
            chk({29'h0, rdata[31:29]}, {29'h0, c});
            #1 chk_lec(3'h7);
            expf |= exp_flags(e);
            apb(1'b0, OFS_IFLAGS, 32'h0);
            chk(rdata, expf);
        end
        for (int j = 0; j < 24; j++) begin
            seed = lfsr(seed);
            e = (seed[7:0] == 8'h0) ? 8'h40 : seed[7:0];
            cec_bus_model_i.send(e, 32'h0);
            #1 chk_lec(exp_code(e));
        end
        apb(1'b1, OFS_IFLAGS, 32'h0);
        apb(1'b0, OFS_IFLAGS, 32'h0);
        chk(rdata, expf);
        apb(1'b1, OFS_IFLAGS, 32'h1e);
        // The stuff strobe lands on the very edge that clears its flag.
        fork
            apb(1'b1, OFS_IFLAGS, 32'h1);
            begin
                @(posedge clk);
                cec_bus_model_i.send(8'h1, 32'h0);
            end
        join
        apb(1'b0, OFS_IFLAGS, 32'h0);
        chk(rdata, 32'h1);
        cec_bus_model_i.send(8'h2, 32'h0);
        apb(1'b1, OFS_IENABLE, 32'h3);
        apb(1'b1, OFS_ISELECT, 32'h2);
        repeat (2) @(posedge clk);
        #1 chk_irq(2'h3);
        apb(1'b1, OFS_IFLAGS, 32'h1);
        repeat (2) @(posedge clk);
        #1 chk_irq(2'h2);
        apb(1'b1, OFS_IENABLE, 32'h0);
        repeat (2) @(posedge clk);
        #1 chk_irq(2'h0);
        seed = lfsr(seed);
        v = {seed, lfsr(seed)};
        cec_bus_model_i.send(8'h0, v);
        apb(1'b0, OFS_IFLAGS, 32'h0);
        chk(rdata, 32'h2 | (v & EXT_FLAG_MASK));
        apb(1'b1, OFS_IFLAGS, 32'hffff_ffff);
        cec_bus_model_i.set_stat(5'h17);
        repeat (3) @(posedge clk);
        apb(1'b0, OFS_IFLAGS, 32'h0);
        chk(rdata, 32'h1c0);
        apb(1'b0, OFS_PSTAT, 32'h0);
        chk({27'h0, rdata[28:24]}, 32'h17);
        apb(1'b0, 8'h60, 32'h0);
        chk({rdata[30:0], serr}, 32'h1);
        cec_bus_model_i.send(8'h1, 32'h0);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        // Status is still set from above, so no change flag may follow reset.
        repeat (3) @(posedge clk);
        apb(1'b0, OFS_IFLAGS, 32'h0);
        chk(rdata, 32'h0);
        #1 chk_lec(3'h7);
        finish_test();
    end
endmodule // testbench
